/* File: pll_scan_pkg.sv */
// shared constants for the pll scan reconfiguration link
package pll_scan_pkg;
    localparam int          NUM_PLLS       = 1;       // configured transceiver plls
    localparam int          IMAGE_BITS     = 144;     // scan chain length per pll
    localparam int          CNT_W          = 8;       // width of bit counters
    localparam int          MCLK_MHZ       = 20;      // controller clock rate
    localparam int          SETTLE_NS      = 4000;    // least wait after frequency lock
    localparam int          SETTLE_CYC     = (SETTLE_NS * MCLK_MHZ + 999) / 1000; // rounded up
    localparam int          SCLK_DIV       = 2;       // mclk cycles per scan clock half period
    localparam int          DONE_DLY       = 2;       // link cycles from update to done
    localparam logic [15:0] WAIT_W_MAX     = 16'hFFFF; // largest value of the 16-bit wait counter
endpackage : pll_scan_pkg

/* File: pll_scan_if.sv */
// link between the transceiver pll scan port and the fabric controller
`timescale 1ns/100ps
interface pll_scan_if #(parameter int N = pll_scan_pkg::NUM_PLLS);
    logic [N-1:0] areset;        // pll reset, controller to pll
    logic [N-1:0] scandata;      // serial config in
    logic [N-1:0] scanclk;       // scan clock, made by controller
    logic [N-1:0] scanclkena;    // scan clock gate
    logic [N-1:0] configupdate;  // apply shifted image
    logic [N-1:0] reconfig_done; // pll finished reconfiguring
    logic [N-1:0] scandataout;   // serial readback of current config
    modport pll  (input areset, scandata, scanclk, scanclkena, configupdate,
                  output reconfig_done, scandataout);
    modport ctrl (output areset, scandata, scanclk, scanclkena, configupdate,
                  input reconfig_done, scandataout);
endinterface : pll_scan_if

/* File: pll_scan_ctrl.sv */
// fabric controller: drives scan chain and sequences pll and channel resets
`timescale 1ns/100ps
module pll_scan_ctrl
    import pll_scan_pkg::*;
#(
    parameter int N      = pll_scan_pkg::NUM_PLLS,    // plls under control
    parameter int BITS   = pll_scan_pkg::IMAGE_BITS,  // image length
    parameter int SETTLE = pll_scan_pkg::SETTLE_CYC   // mclk cycles of settle wait
) (
    input  wire logic         mclk,          // controller clock
    input  wire logic         rst_n,         // async reset, active low
    pll_scan_if.ctrl          link,          // scan port of the transceiver
    input  wire logic [N-1:0] user_areset,   // user pll reset, passed to the pll except in S_WDONE and S_CHAN
    input  wire logic         start,         // begin a reconfiguration, pulse
    input  wire logic [$clog2(N > 1 ? N : 2)-1:0] pll_sel, // pll to reconfigure
    input  wire logic         image_bit,     // next image bit from outside rom
    output logic              image_req,     // image bit consumed this cycle
    output logic              readback_bit,  // captured scan-out bit
    output logic              readback_vld,  // readback_bit valid, pulse
    output logic              chan_req,      // ask for channel reconfiguration
    input  wire logic         chan_done,     // all sharing channels reconfigured
    input  wire logic         rx_freqlocked, // receiver frequency locked, async
    output logic              tx_digitalreset, // channel resets
    output logic              rx_digitalreset,
    output logic              rx_analogreset,
    output logic              busy           // sequence in progress
);
    import pll_scan_pkg::*;

    typedef enum logic [6:0] {
        S_IDLE  = 7'h01, S_SHIFT = 7'h02, S_UPD = 7'h04, S_WDONE = 7'h08,
        S_CHAN  = 7'h10, S_LOCK  = 7'h20, S_SETL = 7'h40
    } st_t;

    st_t              st_r, st_nxt;             // sequencer state
    logic [7:0]       div_r, div_nxt;           // scan clock divider
    logic             sclk_r, sclk_nxt;         // scan clock level
    logic [CNT_W-1:0] cnt_r, cnt_nxt;           // bits shifted
    logic [15:0]      wait_r, wait_nxt;         // settle counter
    logic [N-1:0]     ena_r, ena_nxt, upd_r, upd_nxt, dat_r, dat_nxt, ar_r, ar_nxt;
    logic             req_r, req_nxt, rb_r, rb_nxt, rbv_r, rbv_nxt, cq_r, cq_nxt;
    logic             txd_r, txd_nxt, rxd_r, rxd_nxt, rxa_r, rxa_nxt;
    logic [2:0]       lk_s;                     // freqlock synchroniser
    logic [N-1:0]     dn_s1, dn_s2, dn_s3;      // done synchroniser
    logic             lock_ok, done_ok, sel_so, fall;
    logic             busy_r, busy_nxt;         // registered busy flag, keeps the output on a flop
    logic [N-1:0]     onehot;

    // a rise counts once the second and third stage agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lk_s  <= 3'h0;
            dn_s1 <= '0;
            dn_s2 <= '0;
            dn_s3 <= '0;
        end else begin
            lk_s  <= {lk_s[1:0], rx_freqlocked};
            dn_s1 <= link.reconfig_done;
            dn_s2 <= dn_s1;
            dn_s3 <= dn_s2;
        end
    end

    always_comb begin
        onehot  = '0;
        onehot[pll_sel] = 1'b1;
        lock_ok = lk_s[1] & lk_s[2];
        done_ok = dn_s2[pll_sel] & dn_s3[pll_sel];
        sel_so  = link.scandataout[pll_sel];
        fall    = (div_r == 8'(SCLK_DIV - 1)) & sclk_r; // scan clock about to fall
    end

    // next-state logic for the whole sequence
    always_comb begin
        st_nxt  = st_r;
        div_nxt = (div_r == 8'(SCLK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
        sclk_nxt = (div_r == 8'(SCLK_DIV - 1)) ? ~sclk_r : sclk_r;
        cnt_nxt = cnt_r;
        wait_nxt = wait_r;
        ena_nxt = ena_r;
        upd_nxt = '0;
        dat_nxt = dat_r;
        ar_nxt  = user_areset;                   // user owns it except in S_WDONE and S_CHAN
        req_nxt = 1'b0;
        rb_nxt  = rb_r;
        rbv_nxt = 1'b0;
        cq_nxt  = 1'b0;
        txd_nxt = txd_r;
        rxd_nxt = rxd_r;
        rxa_nxt = rxa_r;
        unique case (st_r)
            S_IDLE: begin
                if (start) begin
                    st_nxt  = S_SHIFT;
                    cnt_nxt = '0;
                    txd_nxt = 1'b1;
                    rxd_nxt = 1'b1;
                    rxa_nxt = 1'b1;
                end
            end
            S_SHIFT: begin                       // data changes on falling scan clock
                if (fall) begin
                    if (cnt_r == CNT_W'(BITS)) begin
                        ena_nxt = '0;            // gate closes before update
                        st_nxt  = S_UPD;
                    end else begin
                        ena_nxt = onehot;
                        dat_nxt = image_bit ? onehot : '0;
                        req_nxt = 1'b1;
                        cnt_nxt = cnt_r + CNT_W'(1);
                        rb_nxt  = sel_so;        // capture readback
                        rbv_nxt = (cnt_r != '0);
                    end
                end
            end
            S_UPD: begin
                upd_nxt = upd_r;                 // strobe holds between scan falls
                if (fall && upd_r == '0) begin
                    upd_nxt = onehot;            // last bit already shifted
                end else if (fall) begin
                    upd_nxt = '0;                // one full scan period, so a rising scan edge sees it
                    st_nxt  = S_WDONE;
                end
            end
            S_WDONE: begin
                ar_nxt = '0;                     // user input ignored
                if (done_ok) begin               // second and third stage agree
                    ar_nxt = onehot;             // first edge seeing done
                    st_nxt = S_CHAN;
                end
            end
            S_CHAN: begin
                ar_nxt = '0;
                cq_nxt = ~chan_done;             // pll first, then channels
                if (chan_done) begin             // waits for all channels
                    txd_nxt = 1'b0;
                    rxa_nxt = 1'b0;
                    st_nxt  = S_LOCK;
                end
            end
            S_LOCK: begin
                wait_nxt = '0;
                if (lock_ok) begin
                    st_nxt = S_SETL;
                end
            end
            S_SETL: begin
                if (!lock_ok) begin
                    st_nxt = S_LOCK;             // lock lost, start waiting again
                end else if (wait_r >= 16'(SETTLE - 1)) begin
                    rxd_nxt = 1'b0;
                    st_nxt  = S_IDLE;
                end else begin
                    wait_nxt = wait_r + 16'h0001;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
        busy_nxt = (st_nxt != S_IDLE);           // same timing as the state, but from a flop
    end

    // registers only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= S_IDLE;
            div_r  <= 8'h00;
            sclk_r <= 1'b0;
            cnt_r  <= '0;
            wait_r <= 16'h0000;
            ena_r  <= '0;
            upd_r  <= '0;
            dat_r  <= '0;
            ar_r   <= '0;
            req_r  <= 1'b0;
            rb_r   <= 1'b0;
            rbv_r  <= 1'b0;
            cq_r   <= 1'b0;
            txd_r  <= 1'b1;                      // channels held in reset from power-up
            rxd_r  <= 1'b1;
            rxa_r  <= 1'b1;
            busy_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            div_r  <= div_nxt;
            sclk_r <= sclk_nxt;
            cnt_r  <= cnt_nxt;
            wait_r <= wait_nxt;
            ena_r  <= ena_nxt;
            upd_r  <= upd_nxt;
            dat_r  <= dat_nxt;
            ar_r   <= ar_nxt;
            req_r  <= req_nxt;
            rb_r   <= rb_nxt;
            rbv_r  <= rbv_nxt;
            cq_r   <= cq_nxt;
            txd_r  <= txd_nxt;
            rxd_r  <= rxd_nxt;
            rxa_r  <= rxa_nxt;
            busy_r <= busy_nxt;
        end
    end

    // scan clock runs free to every pll; the enable picks who shifts
    assign link.scanclk      = {N{sclk_r}};
    assign link.scanclkena   = ena_r;
    assign link.scandata     = dat_r;
    assign link.configupdate = upd_r;
    assign link.areset       = ar_r;
    assign image_req         = req_r;
    assign readback_bit      = rb_r;
    assign readback_vld      = rbv_r;
    assign chan_req          = cq_r;
    assign tx_digitalreset   = txd_r;
    assign rx_digitalreset   = rxd_r;
    assign rx_analogreset    = rxa_r;
    assign busy              = busy_r;
endmodule : pll_scan_ctrl

/* File: pll_scan_port.sv */
// transceiver side: per-pll scan chain, update and done indication
`timescale 1ns/100ps
module pll_scan_port
    import pll_scan_pkg::*;
#(
    parameter int N    = pll_scan_pkg::NUM_PLLS,   // configured plls
    parameter int BITS = pll_scan_pkg::IMAGE_BITS  // chain length
) (
    pll_scan_if.pll               link,      // port toward the controller
    input  wire logic             mclk,      // core clock of the transceiver side
    input  wire logic             rst_n,     // async reset, active low
    output logic [N*BITS-1:0]     active_cfg, // applied configuration per pll
    output logic [N-1:0]          pll_in_reset // pll held by areset, synchronised
);
    import pll_scan_pkg::*;

    // one chain per pll, each on its own scan clock
    for (genvar g = 0; g < N; g++) begin : g_pll
        logic [BITS-1:0] chain_r, chain_nxt;     // shift chain
        logic [BITS-1:0] cfg_r, cfg_nxt;         // applied image
        logic [1:0]      dly_r, dly_nxt;         // update to done delay
        logic            done_r, done_nxt;       // scan-done level
        logic            so_r, so_nxt;           // scan-out
        logic [2:0]      ar_s;                   // areset into mclk domain

        always_comb begin
            chain_nxt = chain_r;
            cfg_nxt   = cfg_r;
            so_nxt    = so_r;
            dly_nxt   = 2'h0;
            done_nxt  = done_r;
            if (link.scanclkena[g]) begin         // gated shift
                chain_nxt = {chain_r[BITS-2:0], link.scandata[g]};
                so_nxt    = chain_r[BITS-1];      // old config leaves first
                done_nxt  = 1'b0;
            end
            if (link.configupdate[g]) begin
                dly_nxt  = 2'(DONE_DLY);
                done_nxt = 1'b0;
            end else if (dly_r != 2'h0) begin
                dly_nxt = dly_r - 2'h1;
                if (dly_r == 2'h1) begin
                    cfg_nxt  = chain_r;           // image takes effect
                    done_nxt = 1'b1;
                end
            end
        end

        // scan domain registers; chain starts from the applied image
        always_ff @(posedge link.scanclk[g] or negedge rst_n) begin
            if (!rst_n) begin
                chain_r <= '0;
                cfg_r   <= '0;
                dly_r   <= 2'h0;
                done_r  <= 1'b0;
                so_r    <= 1'b0;
            end else begin
                chain_r <= chain_nxt;
                cfg_r   <= cfg_nxt;
                dly_r   <= dly_nxt;
                done_r  <= done_nxt;
                so_r    <= so_nxt;
            end
        end

        // areset is asynchronous to mclk, three stages
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                ar_s <= 3'h0;
            end else begin
                ar_s <= {ar_s[1:0], link.areset[g]};
            end
        end

        assign link.reconfig_done[g] = done_r;
        assign link.scandataout[g]   = so_r;
        assign active_cfg[g*BITS +: BITS] = cfg_r;
        assign pll_in_reset[g] = ar_s[2];
    end
endmodule : pll_scan_port

/* File: pll_scan_props.sv */
// concurrent checks on the pll scan link between controller and transceiver port
`timescale 1ns/100ps
module pll_scan_props #(
    parameter int BITS = 144  // scan chain length
) (
    input wire logic       mclk,          // controller clock
    input wire logic       rst_n,         // async reset, active low
    input wire logic [0:0] areset,        // pll reset
    input wire logic [0:0] scandata,      // serial config in
    input wire logic [0:0] scanclk,       // scan clock
    input wire logic [0:0] scanclkena,    // scan clock gate
    input wire logic [0:0] configupdate,  // apply strobe
    input wire logic [0:0] reconfig_done, // pll finished
    input wire logic [0:0] scandataout    // serial readback
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [7:0] ena_cnt_r; // gated scan edges of the current image
    logic       sclk_r;    // scan clock one mclk ago
    // count gated rising scan edges; update clears so each image starts at zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ena_cnt_r <= 8'h00;
            sclk_r    <= 1'b0;
        end else begin
            sclk_r    <= scanclk[0];
            ena_cnt_r <= configupdate[0] ? 8'h00 : ena_cnt_r + {7'h00, scanclk[0] & ~sclk_r & scanclkena[0]};
        end
    end
    // update strobe lasts one scan period of four mclk
    sequence s_upd_pulse;
        configupdate[*4] ##1 !configupdate;
    endsequence
    a_update_after_shift: assert property (configupdate |-> !scanclkena)
        else $error("update while scan enable high");
    a_enable_exact_count: assert property ($fell(scanclkena) |-> ena_cnt_r == 8'(BITS))
        else $error("scan enable spanned wrong edge count");
    a_update_one_period: assert property ($rose(configupdate) |-> s_upd_pulse)
        else $error("update strobe length wrong");
    a_reset_after_done: assert property ($rose(reconfig_done) |-> ##[2:5] areset)
        else $error("pll reset missing after done");
    a_reset_short_pulse: assert property ($rose(areset) && reconfig_done |=> !areset)
        else $error("automatic pll reset not a pulse");
    a_scan_clock_div: assert property ($changed(scanclk) |=> $stable(scanclk) ##1 $changed(scanclk))
        else $error("scan clock divider wrong");
    a_data_on_fall: assert property (scanclkena && $changed(scandata) |-> $fell(scanclk))
        else $error("scan data moved off falling scan clock");
    a_done_after_update: assert property ($rose(configupdate) |-> ##[1:16] reconfig_done)
        else $error("done late after update");
endmodule : pll_scan_props

/* File: test_transceiver_pll_scan_reconfig.sv */
// self-checking bench: controller and transceiver port joined by the scan link
`timescale 1ns/100ps
module test_transceiver_pll_scan_reconfig;
    import pll_scan_pkg::*;
    localparam int SET = 10;  // shortened settle wait keeps the run short
    logic                  mclk = 1'b0, rst_n = 1'b0, start = 1'b0, image_bit = 1'b0;
    logic                  chan_done = 1'b0, rx_freqlocked = 1'b0, seen_ar = 1'b0;
    logic [0:0]            user_areset = 1'b0, pll_in_reset;
    logic                  image_req, readback_bit, readback_vld, chan_req, busy;
    logic                  tx_digitalreset, rx_digitalreset, rx_analogreset;
    logic [IMAGE_BITS-1:0] active_cfg, img_r = '0;
    logic [IMAGE_BITS-1:0] img_a = {9{16'hA5C3}}, img_b = {9{16'h3C5A}};
    logic                  rb[$];     // captured readback bits
    int                    miscompares = 0, total_checks = 0, cyc = 0, nreq = 0;
    pll_scan_if #(.N(1)) link_if();
    pll_scan_ctrl #(.N(1), .BITS(IMAGE_BITS), .SETTLE(SET)) u_pll_scan_ctrl (
        .mclk(mclk), .rst_n(rst_n), .link(link_if), .user_areset(user_areset), .start(start),
        .pll_sel(1'b0), .image_bit(image_bit), .image_req(image_req), .readback_bit(readback_bit),
        .readback_vld(readback_vld), .chan_req(chan_req), .chan_done(chan_done),
        .rx_freqlocked(rx_freqlocked), .tx_digitalreset(tx_digitalreset),
        .rx_digitalreset(rx_digitalreset), .rx_analogreset(rx_analogreset), .busy(busy));
    pll_scan_port #(.N(1), .BITS(IMAGE_BITS)) u_pll_scan_port (
        .link(link_if), .mclk(mclk), .rst_n(rst_n), .active_cfg(active_cfg), .pll_in_reset(pll_in_reset));
    pll_scan_props #(.BITS(IMAGE_BITS)) u_pll_scan_props (
        .mclk(mclk), .rst_n(rst_n), .areset(link_if.areset), .scandata(link_if.scandata),
        .scanclk(link_if.scanclk), .scanclkena(link_if.scanclkena), .configupdate(link_if.configupdate),
        .reconfig_done(link_if.reconfig_done), .scandataout(link_if.scandataout));
    always #25 mclk = ~mclk;  // 20 MHz
    // image feed ahead of each request, readback capture, pll reset watch, hang limit
    always @(posedge mclk) begin
        if (image_req)
            nreq = nreq + 1;
        image_bit <= (nreq < IMAGE_BITS) ? img_r[IMAGE_BITS-1-nreq] : 1'b0;
        if (readback_vld)
            rb.push_back(readback_bit);
        if (link_if.areset[0])
            seen_ar = 1'b1;
        cyc = cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            give_verdict();
        end
    end
    // compare and count; an unknown bit matches only an unknown expected bit
    task automatic chk(input logic [IMAGE_BITS-1:0] got, input logic [IMAGE_BITS-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one full reconfiguration; poke retries start mid-shift, which must be ignored
    task automatic run_cfg(input logic [IMAGE_BITS-1:0] img, input bit poke);
        int k;
        @(negedge mclk);
        img_r = img;
        nreq = 0;
        seen_ar = 1'b0;
        rb.delete();
        @(posedge mclk) start <= 1'b1;
        @(posedge mclk) start <= 1'b0;
        if (poke) begin
            repeat (40) @(posedge mclk);
            start <= 1'b1;
            @(posedge mclk) start <= 1'b0;
        end
        for (k = 0; chan_req !== 1'b1 && k < 3000; k++) @(negedge mclk);
        chk(seen_ar, 1'b1);
        chk(144'(nreq), 144'(IMAGE_BITS));
        chk(active_cfg, img);
        chk({tx_digitalreset, rx_digitalreset, rx_analogreset}, 3'h7);
        @(posedge mclk) chan_done <= 1'b1;
        for (k = 0; chan_req !== 1'b0 && k < 100; k++) @(negedge mclk);
        @(posedge mclk) chan_done <= 1'b0;
        @(negedge mclk);
        chk({tx_digitalreset, rx_digitalreset, rx_analogreset}, 3'h2);
        @(posedge mclk) rx_freqlocked <= 1'b1;
        repeat (4) @(posedge mclk);
        rx_freqlocked <= 1'b0;
        @(posedge mclk) rx_freqlocked <= 1'b1;
        for (k = 0; rx_digitalreset !== 1'b0 && k < 200; k++) @(negedge mclk);
        chk(k >= SET, 1'b1);
        for (k = 0; busy !== 1'b0 && k < 100; k++) @(negedge mclk);
        chk(busy, 1'b0);
        @(posedge mclk) rx_freqlocked <= 1'b0;
    endtask : run_cfg
    // print counts and verdict, then stop
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    // main sequence
    initial begin
        logic [IMAGE_BITS-1:0] got;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        chk({tx_digitalreset, rx_digitalreset, rx_analogreset, busy, link_if.areset}, 5'h1C);
        @(posedge mclk) rst_n <= 1'b1;
        $display("test reset done");
        @(posedge mclk) user_areset <= 1'b1;
        repeat (5) @(negedge mclk);
        chk({link_if.areset, pll_in_reset}, 2'h3);
        @(posedge mclk) user_areset <= 1'b0;
        repeat (5) @(negedge mclk);
        chk({link_if.areset, pll_in_reset}, 2'h0);
        $display("test user reset done");
        run_cfg(img_a, 1'b0);
        $display("test first image done");
        run_cfg(img_b, 1'b1);
        got = img_a;
        for (int i = 0; i < rb.size() && i < IMAGE_BITS; i++) got[IMAGE_BITS-1-i] = rb[i];
        chk(got, img_a);
        chk(rb.size() >= IMAGE_BITS - 2, 1'b1);
        $display("test second image and readback done");
        give_verdict();
    end
endmodule : test_transceiver_pll_scan_reconfig
